// ### src/onboard_peripheral_pin_mux.sv
// Pin sharing logic for DRAM address, peripheral selects and straps
// Operation
// - Byte-three parity pin: parity if strap high, drive write strobe if low.
// - Peripheral traffic moves over an eight-bit data bus to an external buffer.
// - Buffer direction output follows read or write of the transfer.
// - Address bit 0 pin carries boot ROM select outside DRAM cycles.
// - During power-on reset address bits 0, 2, 3 are keyboard port inputs.
// - Address bit 3 pin carries clock-chip read/write outside DRAM cycles.
// - Address bits 4-7 carry four power-control values outside DRAM cycles.
// - Address bit 8 pin carries power latch write strobe outside DRAM cycles.
// - Address bit 2 pin carries clock-chip data select outside DRAM cycles.
// - In ISA memory cycles demux control acts as low-megabyte select.
// - In ISA I/O cycles demux control is held low.
// - Strap low: byte-zero parity pin is an unqualified clock-chip select.
`timescale 1ns/10ps
module onboard_peripheral_pin_mux
  import pin_mux_pkg::*;
(
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          rstn,
  // Core cycle information
  input  wire pin_mux_pkg::cycle_t           cycle_kind,
  input  wire logic [pin_mux_pkg::MA_W-1:0]  dram_addr,
  input  wire logic                          low_meg_n,
  input  wire pin_mux_pkg::periph_req_t      periph_req,
  // Power-control latch request
  input  wire logic                          pc_write_req,
  input  wire logic [pin_mux_pkg::PC_W-1:0]  pc_values,
  output logic                               pc_busy,
  // Parity from the memory controller
  input  wire logic [1:0]                    parity_out,
  input  wire logic                          parity_drive,
  output logic      [1:0]                    parity_in,
  // Peripheral data from core
  input  wire logic [pin_mux_pkg::XD_W-1:0]  xd_wdata,
  output logic      [pin_mux_pkg::XD_W-1:0]  xd_rdata,
  // Shared address pins
  input  wire logic [pin_mux_pkg::MA_W-1:0]  ma_i,
  output logic      [pin_mux_pkg::MA_W-1:0]  ma_o,
  output logic      [pin_mux_pkg::MA_W-1:0]  ma_oe,
  // Parity pins
  input  wire logic                          parity_byte0_pin_i,
  output logic                               parity_byte0_pin_o,
  output logic                               parity_byte0_pin_oe,
  input  wire logic                          parity_byte3_pin_i,
  output logic                               parity_byte3_pin_o,
  output logic                               parity_byte3_pin_oe,
  // Peripheral data bus and its buffer control
  input  wire logic [pin_mux_pkg::XD_W-1:0]  peripheral_data_bus_i,
  output logic      [pin_mux_pkg::XD_W-1:0]  peripheral_data_bus_o,
  output logic                               peripheral_data_bus_oe,
  output logic                               peripheral_buffer_direction,
  output logic                               cycle_demux_control,
  // Values caught at power-on
  output logic                               kbc_port1_bit3,
  output logic                               kbc_port1_bit5,
  output logic                               kbc_port1_bit6,
  output logic                               strap_addr_bit6,
  output logic                               power_on_phase
);

  localparam int SYNC_W = 4 + 2 + XD_W;

  typedef struct packed {
    logic [1:0]        settle;
    logic              strap;
    logic [KBC_W-1:0]  kbc;
    logic [MA_W-1:0]   ma_o;
    logic [MA_W-1:0]   ma_oe;
    pin_drive_t        par0;
    pin_drive_t        par3;
    logic              demux;
    logic              dir;
    logic [XD_W-1:0]   xd_o;
    logic              xd_oe;
    logic [XD_W-1:0]   xd_rdata;
    logic [1:0]        par_in;
  } mux_state_t;

  mux_state_t          st_r;
  mux_state_t          st_nxt;
  logic [SYNC_W-1:0]   sync_v;
  logic [3:0]          ma_sync;
  logic [1:0]          par_sync;
  logic [XD_W-1:0]     xd_sync;
  logic [PC_W-1:0]     pc_vals;
  logic                pc_strobe;
  logic                in_por;
  logic                is_dram;

  // Pin inputs pass two flops
  bit_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in ({ma_i[MA_STRAP], ma_i[MA_RTC_RW], ma_i[MA_RTC_SEL], ma_i[MA_ROM_SEL],
                parity_byte3_pin_i, parity_byte0_pin_i, peripheral_data_bus_i}),
    .sync_out (sync_v)
  );

  assign ma_sync  = sync_v[SYNC_W-1 -: 4];
  assign par_sync = sync_v[XD_W +: 2];
  assign xd_sync  = sync_v[XD_W-1:0];
  assign in_por   = (st_r.settle != 2'h0);
  assign is_dram  = (cycle_kind == CYC_DRAM);

  power_latch_seq u_pc (
    .clock    (clock),
    .rstn     (rstn),
    .start    (pc_write_req),
    .values   (pc_values),
    .allow    (!in_por && !is_dram),
    .busy     (pc_busy),
    .vals_o   (pc_vals),
    .strobe_o (pc_strobe)
  );

  always_comb begin
    st_nxt = st_r;
    if (in_por) begin
      // Pins float as inputs until the strap window closes
      st_nxt.ma_oe  = '0;
      st_nxt.par0   = '{o: 1'b1, oe: 1'b0};
      st_nxt.par3   = '{o: 1'b1, oe: 1'b0};
      st_nxt.xd_oe  = 1'b0;
      st_nxt.dir    = 1'b0;
      st_nxt.demux  = 1'b1;
      st_nxt.settle = st_r.settle - 2'h1;
      if (st_r.settle == 2'h1) begin
        st_nxt.strap = ma_sync[3];
        st_nxt.kbc   = ma_sync[2:0];
      end
    end else begin
      unique case (cycle_kind)
        CYC_DRAM:    st_nxt.demux = 1'b1;
        CYC_ISA_MEM: st_nxt.demux = low_meg_n;
        CYC_ISA_IO:  st_nxt.demux = 1'b0;
        CYC_IDLE:    st_nxt.demux = 1'b1;
      endcase
      st_nxt.ma_oe = '1;
      if (is_dram) begin
        st_nxt.ma_o = dram_addr;
      end else begin
        st_nxt.ma_o                    = MA_IDLE;
        st_nxt.ma_o[MA_ROM_SEL]        = !periph_req.rom_sel;
        st_nxt.ma_o[MA_RTC_SEL]        = !periph_req.rtc_sel;
        st_nxt.ma_o[MA_RTC_RW]         = periph_req.rtc_read;
        st_nxt.ma_o[MA_PC_LSB +: PC_W] = pc_vals;
        st_nxt.ma_o[MA_PC_WE]          = !pc_strobe;
      end
      if (st_r.strap) begin
        st_nxt.par0 = '{o: parity_out[0], oe: parity_drive};
        st_nxt.par3 = '{o: parity_out[1], oe: parity_drive};
      end else begin
        st_nxt.par0 = '{o: !periph_req.rtc_sel, oe: 1'b1};
        st_nxt.par3 = '{o: !periph_req.drive_wr, oe: 1'b1};
      end
      st_nxt.dir   = periph_req.xd_active && periph_req.xd_read;
      st_nxt.xd_oe = periph_req.xd_active && !periph_req.xd_read;
      st_nxt.xd_o  = xd_wdata;
      if (periph_req.xd_active && periph_req.xd_read) begin
        st_nxt.xd_rdata = xd_sync;
      end
    end
    st_nxt.par_in = par_sync;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{settle: SETTLE_INIT, strap: 1'b1, kbc: '0, ma_o: MA_IDLE, ma_oe: '0,
                par0: '{o: 1'b1, oe: 1'b0}, par3: '{o: 1'b1, oe: 1'b0},
                demux: 1'b1, dir: 1'b0, xd_o: XD_RESET, xd_oe: 1'b0,
                xd_rdata: XD_RESET, par_in: 2'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ma_o                        = st_r.ma_o;
  assign ma_oe                       = st_r.ma_oe;
  assign parity_byte0_pin_o          = st_r.par0.o;
  assign parity_byte0_pin_oe         = st_r.par0.oe;
  assign parity_byte3_pin_o          = st_r.par3.o;
  assign parity_byte3_pin_oe         = st_r.par3.oe;
  assign parity_in                   = st_r.par_in;
  assign peripheral_data_bus_o       = st_r.xd_o;
  assign peripheral_data_bus_oe      = st_r.xd_oe;
  assign peripheral_buffer_direction = st_r.dir;
  assign cycle_demux_control         = st_r.demux;
  assign xd_rdata                    = st_r.xd_rdata;
  assign kbc_port1_bit3              = st_r.kbc[0];
  assign kbc_port1_bit5              = st_r.kbc[1];
  assign kbc_port1_bit6              = st_r.kbc[2];
  assign strap_addr_bit6             = st_r.strap;
  assign power_on_phase              = in_por;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  parity_strap_a: assert property (
    (!in_por && st_r.strap) |=> (parity_byte3_pin_o == $past(parity_out[1])
                                 && parity_byte3_pin_oe == $past(parity_drive)))
    else $error("byte3 parity pin not carrying parity");

  drive_strobe_a: assert property (
    (!in_por && !st_r.strap) |=> (parity_byte3_pin_oe
                                  && parity_byte3_pin_o == !$past(periph_req.drive_wr)))
    else $error("byte3 pin not carrying drive write strobe");

  xd_write_a: assert property (
    (!in_por && periph_req.xd_active && !periph_req.xd_read)
      |=> (peripheral_data_bus_oe && peripheral_data_bus_o == $past(xd_wdata)
           && !peripheral_buffer_direction))
    else $error("peripheral write data not driven");

  xd_dir_a: assert property (
    (!in_por && periph_req.xd_active && periph_req.xd_read)
      |=> (peripheral_buffer_direction && !peripheral_data_bus_oe))
    else $error("buffer direction wrong on read");

  rom_sel_a: assert property (
    (!in_por && !is_dram) |=> ma_o[MA_ROM_SEL] == !$past(periph_req.rom_sel))
    else $error("boot ROM select wrong");

  por_inputs_a: assert property (
    $rose(rstn) |-> (ma_oe == '0) [*4] ##1 (ma_oe == '1))
    else $error("shared pins driven during power-on window");

  rtc_rw_a: assert property (
    (!in_por && !is_dram) |=> ma_o[MA_RTC_RW] == $past(periph_req.rtc_read))
    else $error("clock-chip read/write wrong");

  pc_vals_a: assert property (
    (!in_por && !is_dram) |=> ma_o[MA_PC_LSB +: PC_W] == $past(pc_vals))
    else $error("power-control values not on pins");

  pc_we_a: assert property (
    (!in_por && !is_dram && pc_strobe) |=> !ma_o[MA_PC_WE])
    else $error("latch strobe missing on pin");

  rtc_sel_a: assert property (
    (!in_por && !is_dram) |=> ma_o[MA_RTC_SEL] == !$past(periph_req.rtc_sel))
    else $error("clock-chip data select wrong");

  demux_dram_a: assert property (
    (!in_por && is_dram) |=> (cycle_demux_control && ma_o == $past(dram_addr)))
    else $error("DRAM cycle without demux high");

  low_megabyte_select_a: assert property (
    (!in_por && cycle_kind == CYC_ISA_MEM) |=> cycle_demux_control == $past(low_meg_n))
    else $error("low-megabyte select wrong");

  demux_io_a: assert property (
    (!in_por && cycle_kind == CYC_ISA_IO) |=> !cycle_demux_control)
    else $error("demux not low in I/O cycle");

  rtc_unqual_a: assert property (
    (!in_por && !st_r.strap) |=> (parity_byte0_pin_oe
                                  && parity_byte0_pin_o == !$past(periph_req.rtc_sel)))
    else $error("byte0 pin not carrying clock-chip select");

endmodule : onboard_peripheral_pin_mux

// ### inc/pin_mux_pkg.sv
// Shared constants and types for the peripheral pin sharing block
package pin_mux_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int PC_STROBE_NS  = 100;
  localparam int PC_STROBE_CYC = (PC_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PC_CNT_W      = 2;

  // Pin group widths
  localparam int MA_W  = 9;
  localparam int XD_W  = 8;
  localparam int PC_W  = 4;
  localparam int KBC_W = 3;

  // Shared address pin positions
  localparam int MA_ROM_SEL = 0;
  localparam int MA_RTC_SEL = 2;
  localparam int MA_RTC_RW  = 3;
  localparam int MA_PC_LSB  = 4;
  localparam int MA_STRAP   = 6;
  localparam int MA_PC_WE   = 8;

  // Reset values and settle window after reset release
  localparam logic [1:0]      SETTLE_INIT = 2'h3;
  localparam logic [PC_W-1:0] PC_RESET    = 4'h0;
  localparam logic [MA_W-1:0] MA_IDLE     = 9'h1ff;
  localparam logic [XD_W-1:0] XD_RESET    = 8'h00;

  typedef enum logic [1:0] {
    CYC_IDLE    = 2'b00,
    CYC_DRAM    = 2'b01,
    CYC_ISA_MEM = 2'b10,
    CYC_ISA_IO  = 2'b11
  } cycle_t;

  typedef enum logic [1:0] {
    PC_IDLE   = 2'b00,
    PC_SETUP  = 2'b01,
    PC_STROBE = 2'b10,
    PC_HOLD   = 2'b11
  } pc_state_t;

  // Core request for the current non-DRAM cycle
  typedef struct packed {
    logic rom_sel;
    logic rtc_sel;
    logic rtc_read;
    logic drive_wr;
    logic xd_active;
    logic xd_read;
  } periph_req_t;

  // One driven pin
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_t;

endpackage : pin_mux_pkg

// ### src/bit_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.s2;

endmodule : bit_sync

// ### src/power_latch_seq.sv
// Sequencer for the external power-control latch write
`timescale 1ns/10ps
module power_latch_seq
  import pin_mux_pkg::*;
(
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         rstn,
  // Request from core
  input  wire logic                         start,
  input  wire logic [pin_mux_pkg::PC_W-1:0] values,
  input  wire logic                         allow,
  output logic                              busy,
  // Toward the shared pins
  output logic      [pin_mux_pkg::PC_W-1:0] vals_o,
  output logic                              strobe_o
);

  typedef struct packed {
    pc_state_t            state;
    logic [PC_CNT_W-1:0]  cnt;
    logic [PC_W-1:0]      vals;
    logic                 strobe;
  } pc_seq_t;

  pc_seq_t st_r;
  pc_seq_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r.state)
      PC_IDLE: begin
        if (start && allow) begin
          st_nxt.vals  = values;
          st_nxt.state = PC_SETUP;
        end
      end
      PC_SETUP: begin
        st_nxt.strobe = 1'b1;
        st_nxt.cnt    = PC_CNT_W'(PC_STROBE_CYC - 1);
        st_nxt.state  = PC_STROBE;
      end
      PC_STROBE: begin
        if (st_r.cnt == '0) begin
          st_nxt.strobe = 1'b0;
          st_nxt.state  = PC_HOLD;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      PC_HOLD: begin
        st_nxt.state = PC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{state: PC_IDLE, cnt: '0, vals: PC_RESET, strobe: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy     = (st_r.state != PC_IDLE);
  assign vals_o   = st_r.vals;
  assign strobe_o = st_r.strobe;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  strobe_stable_a: assert property (
    (st_r.strobe || st_r.state == PC_HOLD) |-> $stable(st_r.vals))
    else $error("latch values changed while strobe held");

  strobe_width_a: assert property (
    $rose(st_r.strobe) |-> st_r.strobe [*2] ##1 !st_r.strobe)
    else $error("latch strobe width wrong");

endmodule : power_latch_seq

// ### testbench/ext_board_model.sv
// Board side model: straps, pull-ups, power latches and peripheral bus
`timescale 1ns/10ps
module ext_board_model
  import pin_mux_pkg::*;
(
  // Bench controls
  input  wire logic                         strap_en,
  input  wire logic [pin_mux_pkg::MA_W-1:0] strap_val,
  input  wire logic [pin_mux_pkg::XD_W-1:0] periph_val,
  // Shared address pins and demux
  input  wire logic [pin_mux_pkg::MA_W-1:0] ma_o,
  input  wire logic [pin_mux_pkg::MA_W-1:0] ma_oe,
  input  wire logic                         demux,
  output logic      [pin_mux_pkg::MA_W-1:0] ma_i,
  // Parity pins
  input  wire logic                         p0_o,
  input  wire logic                         p0_oe,
  input  wire logic                         p3_o,
  input  wire logic                         p3_oe,
  output logic                              p0_i,
  output logic                              p3_i,
  // Peripheral data bus
  input  wire logic [pin_mux_pkg::XD_W-1:0] xd_o,
  input  wire logic                         xd_oe,
  output logic      [pin_mux_pkg::XD_W-1:0] xd_i,
  // Nibble held by the external latches
  output logic      [pin_mux_pkg::PC_W-1:0] latch_q
);
  // Released pins show the strap resistors or the pull-ups
  always_comb begin
    for (int i = 0; i < MA_W; i++) begin
      ma_i[i] = ma_oe[i] ? ma_o[i] : (strap_en ? strap_val[i] : 1'h1);
    end
  end
  assign p0_i = p0_oe ? p0_o : 1'h1;
  assign p3_i = p3_oe ? p3_o : 1'h1;
  // Selected peripheral answers while the bus is released
  assign xd_i = xd_oe ? xd_o : periph_val;
  // Latch closes when the demux-qualified strobe ends
  always @(posedge (ma_o[MA_PC_WE] | demux)) begin
    latch_q <= ma_o[MA_PC_LSB +: PC_W];
  end
endmodule : ext_board_model

// ### testbench/onboard_peripheral_pin_mux_tb_top.sv
// Self-checking bench for the peripheral pin sharing block
`timescale 1ns/10ps
module onboard_peripheral_pin_mux_tb_top;
  import pin_mux_pkg::*;
  logic            clock        = 1'h0;
  logic            rstn         = 1'h0;
  cycle_t          cycle_kind   = CYC_IDLE;
  logic [MA_W-1:0] dram_addr    = 9'h000;
  logic            low_meg_n    = 1'h1;
  periph_req_t     periph_req   = 6'h00;
  logic            pc_write_req = 1'h0;
  logic [PC_W-1:0] pc_values    = 4'h0;
  logic [1:0]      parity_out   = 2'h0;
  logic            parity_drive = 1'h0;
  logic [XD_W-1:0] xd_wdata     = 8'h00;
  logic            strap_en     = 1'h1;
  logic [MA_W-1:0] strap_val    = 9'h000;
  logic [XD_W-1:0] periph_val   = 8'h00;
  logic            pc_busy, p0_i, p0_o, p0_oe, p3_i, p3_o, p3_oe, xd_oe, xd_dir, demux;
  logic            kbc3, kbc5, kbc6, strap6, pon;
  logic [1:0]      parity_in;
  logic [XD_W-1:0] xd_rdata, xd_i, xd_o;
  logic [MA_W-1:0] ma_i, ma_o, ma_oe;
  logic [PC_W-1:0] latch_q;
  int              error_cnt    = 0;
  int              checks_done  = 0;

  always #(CLK_PERIOD_NS / 2) clock = ~clock;

  onboard_peripheral_pin_mux u_dut (
    .clock(clock), .rstn(rstn), .cycle_kind(cycle_kind), .dram_addr(dram_addr),
    .low_meg_n(low_meg_n), .periph_req(periph_req), .pc_write_req(pc_write_req),
    .pc_values(pc_values), .pc_busy(pc_busy), .parity_out(parity_out),
    .parity_drive(parity_drive), .parity_in(parity_in), .xd_wdata(xd_wdata),
    .xd_rdata(xd_rdata), .ma_i(ma_i), .ma_o(ma_o), .ma_oe(ma_oe),
    .parity_byte0_pin_i(p0_i), .parity_byte0_pin_o(p0_o), .parity_byte0_pin_oe(p0_oe),
    .parity_byte3_pin_i(p3_i), .parity_byte3_pin_o(p3_o), .parity_byte3_pin_oe(p3_oe),
    .peripheral_data_bus_i(xd_i), .peripheral_data_bus_o(xd_o),
    .peripheral_data_bus_oe(xd_oe), .peripheral_buffer_direction(xd_dir),
    .cycle_demux_control(demux), .kbc_port1_bit3(kbc3), .kbc_port1_bit5(kbc5),
    .kbc_port1_bit6(kbc6), .strap_addr_bit6(strap6), .power_on_phase(pon)
  );

  ext_board_model u_board (
    .strap_en(strap_en), .strap_val(strap_val), .periph_val(periph_val), .ma_o(ma_o),
    .ma_oe(ma_oe), .demux(demux), .ma_i(ma_i), .p0_o(p0_o), .p0_oe(p0_oe), .p3_o(p3_o),
    .p3_oe(p3_oe), .p0_i(p0_i), .p3_i(p3_i), .xd_o(xd_o), .xd_oe(xd_oe), .xd_i(xd_i),
    .latch_q(latch_q)
  );

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic power_on(input logic [MA_W-1:0] straps);
    @(posedge clock);
    rstn <= 1'h0;
    strap_en <= 1'h1;
    strap_val <= straps;
    cycle_kind <= CYC_IDLE;
    periph_req <= 6'h00;
    repeat (20) @(posedge clock);
    #1;
    chk(ma_oe, 9'h000, "address pins driven in reset");
    @(posedge clock);
    rstn <= 1'h1;
    repeat (2) @(posedge clock);
    #1;
    chk(ma_oe, 9'h000, "address pins driven in power-on window");
    chk(pon, 1'h1, "power-on phase in window");
    repeat (4) @(posedge clock);
    #1;
    chk({kbc6, kbc5, kbc3}, {straps[3], straps[2], straps[0]}, "keyboard port bits");
    chk(strap6, straps[MA_STRAP], "strap bit six");
    chk(pon, 1'h0, "power-on phase after window");
    chk(ma_oe, 9'h1ff, "address pins driven after window");
    chk(demux, 1'h1, "demux in idle cycle");
    @(posedge clock);
    strap_en <= 1'h0;
  endtask : power_on

  task automatic io_case(input logic rom, input logic rtc, input logic rd);
    @(posedge clock);
    cycle_kind <= CYC_ISA_IO;
    periph_req <= '{rom_sel: rom, rtc_sel: rtc, rtc_read: rd, default: 1'h0};
    @(posedge clock);
    #1;
    chk(ma_o[MA_ROM_SEL], !rom, "boot rom select");
    chk(ma_o[MA_RTC_SEL], !rtc, "clock chip select");
    chk(ma_o[MA_RTC_RW], rd, "clock chip read write");
    chk(ma_oe, 9'h1ff, "select pins driven");
    chk(demux, 1'h0, "demux in io cycle");
  endtask : io_case

  task automatic dram_and_mem;
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      cycle_kind <= CYC_DRAM;
      dram_addr <= k[0] ? 9'h15a : 9'h0a5;
      @(posedge clock);
      #1;
      chk(ma_o, k[0] ? 9'h15a : 9'h0a5, "dram address");
      chk(demux, 1'h1, "demux in dram cycle");
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      cycle_kind <= CYC_ISA_MEM;
      low_meg_n <= k[0];
      @(posedge clock);
      #1;
      chk(demux, k[0], "demux in memory cycle");
    end
  endtask : dram_and_mem

  task automatic latch_write(input logic [PC_W-1:0] v);
    int lows;
    lows = 0;
    @(posedge clock);
    cycle_kind <= CYC_ISA_IO;
    pc_values <= v;
    pc_write_req <= 1'h1;
    @(posedge clock);
    pc_write_req <= 1'h0;
    pc_values <= ~v;
    #1;
    chk(pc_busy, 1'h1, "latch write accepted");
    for (int i = 0; i < 10; i++) begin
      if (ma_o[MA_PC_WE] === 1'h0) begin
        lows++;
        chk(ma_o[MA_PC_LSB +: PC_W], v, "power values under strobe");
      end
      @(posedge clock);
      #1;
    end
    chk(lows, PC_STROBE_CYC, "latch strobe width");
    chk(pc_busy, 1'h0, "latch write finished");
    chk(latch_q, v, "latched power values");
  endtask : latch_write

  task automatic parity_mode;
    @(posedge clock);
    parity_out <= 2'h2;
    parity_drive <= 1'h1;
    @(posedge clock);
    #1;
    chk({p3_oe, p3_o, p0_oe, p0_o}, 4'he, "parity driven");
    repeat (3) @(posedge clock);
    #1;
    chk(parity_in, 2'h2, "parity pins read back");
    @(posedge clock);
    parity_drive <= 1'h0;
    @(posedge clock);
    #1;
    chk({p3_oe, p0_oe}, 2'h0, "parity released");
    repeat (3) @(posedge clock);
    #1;
    chk(parity_in, 2'h3, "released parity pins read back");
  endtask : parity_mode

  task automatic periph_bus;
    @(posedge clock);
    cycle_kind <= CYC_ISA_IO;
    xd_wdata <= 8'h96;
    periph_req <= '{xd_active: 1'h1, default: 1'h0};
    @(posedge clock);
    #1;
    chk({xd_oe, xd_dir}, 2'h2, "write direction");
    chk(xd_o, 8'h96, "write data");
    @(posedge clock);
    periph_val <= 8'h3c;
    periph_req <= '{xd_active: 1'h1, xd_read: 1'h1, default: 1'h0};
    repeat (5) @(posedge clock);
    #1;
    chk({xd_oe, xd_dir}, 2'h1, "read direction");
    chk(xd_rdata, 8'h3c, "read data");
  endtask : periph_bus

  task automatic strap_low_pins;
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      cycle_kind <= CYC_ISA_IO;
      periph_req <= '{rtc_sel: k[0], drive_wr: !k[0], default: 1'h0};
      @(posedge clock);
      #1;
      chk({p0_oe, p0_o}, {1'h1, !k[0]}, "unqualified clock chip select");
      chk({p3_oe, p3_o}, {1'h1, k[0]}, "drive write strobe");
    end
  endtask : strap_low_pins

  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    $display("unexpected at %0t: run did not finish", $time);
    wrap_up();
  end

  initial begin
    power_on(9'h048);
    io_case(1'h1, 1'h0, 1'h1);
    io_case(1'h0, 1'h1, 1'h0);
    dram_and_mem();
    latch_write(4'ha);
    latch_write(4'h5);
    parity_mode();
    periph_bus();
    power_on(9'h005);
    strap_low_pins();
    wrap_up();
  end
endmodule : onboard_peripheral_pin_mux_tb_top
